/* File: hdl/msic_pkg.sv */
// constants and types shared by the motion sensor interrupt controller
package msic_pkg;

	// ----------------------------------------------------------------
	// clock and time base
	// ----------------------------------------------------------------
	localparam int CLK_MHZ        = 250;     // pclk rate in MHz
	localparam int TICK_US        = 250;     // hold timer tick in us
	localparam int TICK_CYC       = TICK_US * CLK_MHZ;
	localparam int ND_QUIET_US    = 50;      // new-data low time in us
	localparam int ND_QUIET_CYC   = ND_QUIET_US * CLK_MHZ;
	localparam int STARTUP_MS     = 2;       // pin undefined after power-up
	localparam int STARTUP_CYC    = STARTUP_MS * 1000 * CLK_MHZ;
	localparam int FIXED_HOLD_US  = 12500;   // own non-latched hold of orient and flat

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [5:0] IDX_STATUS = 6'h09;  // engine status
	localparam logic [5:0] IDX_NDSTAT = 6'h0A;  // new-data status
	localparam logic [5:0] IDX_EN_ENG = 6'h16;  // engine enables
	localparam logic [5:0] IDX_EN_ND  = 6'h17;  // new-data enable
	localparam logic [5:0] IDX_MAP1   = 6'h19;  // map to first pin
	localparam logic [5:0] IDX_MAP_RS = 6'h1A;  // reserved map slot
	localparam logic [5:0] IDX_MAP2   = 6'h1B;  // map to second pin
	localparam logic [5:0] IDX_SRC    = 6'h1E;  // data source select
	localparam logic [5:0] IDX_PINCFG = 6'h20;  // pin level and driver
	localparam logic [5:0] IDX_MODE   = 6'h21;  // mode and latch clear

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int NUM_ENG      = 7;  // engines besides new data
	localparam int ENG_ORIENT   = 5;  // orientation engine index
	localparam int ENG_FLAT     = 6;  // flat engine index
	localparam int BIT_ND       = 7;  // new-data bit in status and maps
	localparam int BIT_ND_EN    = 0;  // new-data enable bit
	localparam int BIT_SRC_DATA = 0;
	localparam int BIT_SRC_TAP  = 1;
	localparam int BIT_SRC_SLP  = 2;
	localparam int BIT_SRC_LOW  = 3;
	localparam int BIT_P1_POL   = 0;
	localparam int BIT_P1_DRV   = 1;
	localparam int BIT_P2_POL   = 2;
	localparam int BIT_P2_DRV   = 3;
	localparam int BIT_RST_INT  = 7;  // write one clears latched status

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] RST_PINCFG = 4'hF;  // active high, push-pull
	localparam logic [3:0] RST_MODE   = 4'h0;  // non-latched

	// common interrupt mode class
	typedef enum logic [1:0] {
		MC_NONLATCH,
		MC_LATCH,
		MC_TEMP
	} msic_mode_type;

endpackage : msic_pkg

/* File: hdl/msic_top.sv */
// motion sensor interrupt controller with apb register access
`timescale 1ns/100ps

module msic_top
	import msic_pkg::*;
#(
	parameter int TICK_CYCLES    = TICK_CYC,     // cycles per hold tick
	parameter int QUIET_CYCLES   = ND_QUIET_CYC, // new-data low time
	parameter int STARTUP_CYCLES = STARTUP_CYC   // pin release delay
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// engine side, same clock
	input  wire logic [NUM_ENG-1:0]  eng_cond,
	input  wire logic                acc_update,
	input  wire logic                z_stored,
	input  wire logic                acq_start,
	// source selects toward the engines
	output logic                     src_data,
	output logic                     src_tap,
	output logic                     src_slope,
	output logic                     src_low,
	// interrupt pins
	output logic                     irq_pin_first,
	output logic                     irq_pin_first_oe,
	output logic                     irq_pin_second,
	output logic                     irq_pin_second_oe
);

	// ----------------------------------------------------------------
	// hold decode
	// ----------------------------------------------------------------

	// mode field to mode class
	function automatic msic_mode_type mode_class(input logic [3:0] m);
		if (m[2:0] == 3'h7) begin
			mode_class = MC_LATCH;
		end else if (m[2:0] == 3'h0) begin
			mode_class = MC_NONLATCH;
		end else begin
			mode_class = MC_TEMP;
		end
	endfunction : mode_class

	// temporary hold in ticks for a mode code
	function automatic logic [15:0] mode_hold(input logic [3:0] m);
		case (m)
			4'h1: mode_hold = 16'(250000 / TICK_US);
			4'h2: mode_hold = 16'(500000 / TICK_US);
			4'h3: mode_hold = 16'(1000000 / TICK_US);
			4'h4: mode_hold = 16'(2000000 / TICK_US);
			4'h5: mode_hold = 16'(4000000 / TICK_US);
			4'h6: mode_hold = 16'(8000000 / TICK_US);
			4'h9: mode_hold = 16'(500 / TICK_US);
			4'hA: mode_hold = 16'(500 / TICK_US);
			4'hB: mode_hold = 16'(1000 / TICK_US);
			4'hC: mode_hold = 16'(12500 / TICK_US);
			4'hD: mode_hold = 16'(25000 / TICK_US);
			4'hE: mode_hold = 16'(50000 / TICK_US);
			default: mode_hold = 16'hFFFF;              // unused code
		endcase
	endfunction : mode_hold

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic [NUM_ENG-1:0] en_eng_q;     // engine enables
	logic               en_nd_q;      // new-data enable
	logic [7:0]         map1_q;       // first pin map
	logic [7:0]         map2_q;       // second pin map
	logic [3:0]         src_q;        // source selects
	logic [3:0]         pincfg_q;     // pin polarity and driver
	logic [3:0]         mode_q;       // common mode
	logic               pready_q;     // apb answer
	logic [31:0]        prdata_q;     // read data
	logic               pslverr_q;    // unmapped address answer

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	wire        acc_phase = psel & penable;
	wire        wr_take   = acc_phase & pwrite & pready_q;
	wire [5:0]  reg_idx   = paddr[7:2];
	wire        aligned   = (paddr[1:0] == 2'b00);
	wire        clr_latch;
	logic [31:0] rd_data;             // read mux
	logic        hit;                 // address maps to a register
	logic [NUM_ENG-1:0] st_vec;       // engine status bits
	logic        nd_st_q;             // new-data status

	// read mux and hit decode
	always_comb begin
		rd_data = 32'h0000_0000;
		hit     = aligned;
		if (reg_idx == IDX_STATUS) begin
			rd_data[NUM_ENG-1:0] = st_vec;
		end else if (reg_idx == IDX_NDSTAT) begin
			rd_data[BIT_ND] = nd_st_q;
		end else if (reg_idx == IDX_EN_ENG) begin
			rd_data[NUM_ENG-1:0] = en_eng_q;
		end else if (reg_idx == IDX_EN_ND) begin
			rd_data[BIT_ND_EN] = en_nd_q;
		end else if (reg_idx == IDX_MAP1) begin
			rd_data[7:0] = map1_q;
		end else if (reg_idx == IDX_MAP_RS) begin
			rd_data = 32'h0000_0000;               // reserved, reads zero
		end else if (reg_idx == IDX_MAP2) begin
			rd_data[7:0] = map2_q;
		end else if (reg_idx == IDX_SRC) begin
			rd_data[3:0] = src_q;
		end else if (reg_idx == IDX_PINCFG) begin
			rd_data[3:0] = pincfg_q;
		end else if (reg_idx == IDX_MODE) begin
			rd_data[3:0] = mode_q;                 // clear bit reads zero
		end else begin
			hit = 1'b0;
		end
	end

	// write strobe for one register index
	function automatic logic wr_hit(input logic [5:0] idx,
		input logic [5:0] sel, input logic take, input logic al);
		wr_hit = take & al & (idx == sel);
	endfunction : wr_hit

	assign clr_latch = wr_hit(reg_idx, IDX_MODE, wr_take, aligned)
		& pwdata[BIT_RST_INT];

	// answer one cycle into the access phase, data from a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= acc_phase & ~pready_q;
			prdata_q  <= (acc_phase & ~pwrite & hit) ? rd_data
				: 32'h0000_0000;
			pslverr_q <= acc_phase & ~pready_q & ~hit;
		end
	end

	// configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_eng_q <= '0;
			en_nd_q  <= 1'b0;
			map1_q   <= 8'h00;
			map2_q   <= 8'h00;
			src_q    <= 4'h0;
			pincfg_q <= RST_PINCFG;
			mode_q   <= RST_MODE;
		end else begin
			if (wr_hit(reg_idx, IDX_EN_ENG, wr_take, aligned)) begin
				en_eng_q <= pwdata[NUM_ENG-1:0];
			end
			if (wr_hit(reg_idx, IDX_EN_ND, wr_take, aligned)) begin
				en_nd_q <= pwdata[BIT_ND_EN];
			end
			if (wr_hit(reg_idx, IDX_MAP1, wr_take, aligned)) begin
				map1_q <= pwdata[7:0];
			end
			if (wr_hit(reg_idx, IDX_MAP2, wr_take, aligned)) begin
				map2_q <= pwdata[7:0];
			end
			if (wr_hit(reg_idx, IDX_SRC, wr_take, aligned)) begin
				src_q <= pwdata[3:0];
			end
			if (wr_hit(reg_idx, IDX_PINCFG, wr_take, aligned)) begin
				pincfg_q <= pwdata[3:0];
			end
			if (wr_hit(reg_idx, IDX_MODE, wr_take, aligned)) begin
				mode_q <= pwdata[3:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// hold tick divided down from pclk
	// ----------------------------------------------------------------
	logic [31:0] tick_cnt_q;          // cycles within a tick
	wire         tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));

	// free running tick divider
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_q <= 32'h0000_0000;
		end else if (tick) begin
			tick_cnt_q <= 32'h0000_0000;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
		end
	end

	// ----------------------------------------------------------------
	// engine status
	// ----------------------------------------------------------------
	msic_mode_type mcls;              // common mode class
	logic [15:0]   hold_sel;          // selected temporary hold
	assign mcls     = mode_class(mode_q);
	assign hold_sel = mode_hold(mode_q);

	// orientation and flat take filtered data only, so no select
	// exists for them: the source outputs cover the other engines
	genvar gi;
	generate
		for (gi = 0; gi < NUM_ENG; gi++) begin : g_eng
			logic        st_q;            // status bit
			logic [15:0] hcnt_q;          // ticks since assertion
			wire fixed = (gi == ENG_ORIENT) || (gi == ENG_FLAT);
			wire [15:0] hold = (fixed && mcls == MC_NONLATCH)
				? 16'(FIXED_HOLD_US / TICK_US) : hold_sel;
			wire expired = (hcnt_q >= hold);
			wire cond    = eng_cond[gi];
			wire set_now = acc_update & cond;
			logic clr;                    // clear request this cycle

			// clear causes by mode; live condition blocks timed clears
			always_comb begin
				clr = 1'b0;
				case (mcls)
					MC_NONLATCH: begin
						if (fixed) begin
							clr = expired & ~cond;
						end else begin
							clr = acc_update & ~cond;
						end
					end
					MC_LATCH: begin
						clr = clr_latch;
					end
					default: begin
						clr = expired & ~cond;
					end
				endcase
			end

			// status and hold counter; set wins over clear
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					st_q   <= 1'b0;
					hcnt_q <= 16'h0000;
				end else if (!en_eng_q[gi]) begin
					st_q   <= 1'b0;
					hcnt_q <= 16'h0000;
				end else if (set_now) begin
					st_q <= 1'b1;
					if (!st_q) begin
						hcnt_q <= 16'h0000;
					end
				end else if (st_q && clr) begin
					st_q <= 1'b0;
				end else if (st_q && tick && !expired) begin
					hcnt_q <= hcnt_q + 16'h0001;
				end
			end

			assign st_vec[gi] = st_q;
		end
	endgenerate

	// ----------------------------------------------------------------
	// new-data interrupt, always non-latched
	// ----------------------------------------------------------------
	logic [31:0] quiet_q;             // cycles left of forced low time

	// cleared at acquisition start, then held low the quiet time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nd_st_q <= 1'b0;
			quiet_q <= 32'h0000_0000;
		end else if (!en_nd_q) begin
			nd_st_q <= 1'b0;
			quiet_q <= 32'h0000_0000;
		end else if (acq_start) begin
			nd_st_q <= 1'b0;
			quiet_q <= 32'(QUIET_CYCLES);
		end else begin
			if (quiet_q != 32'h0000_0000) begin
				quiet_q <= quiet_q - 32'h0000_0001;
			end else if (z_stored) begin
				nd_st_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// pin drive
	// ----------------------------------------------------------------
	wire [7:0] all_st = {nd_st_q, st_vec};
	wire lvl1 = |(all_st & map1_q);
	wire lvl2 = |(all_st & map2_q);
	// polarity applied after the OR
	wire pin1 = pincfg_q[BIT_P1_POL] ? lvl1 : ~lvl1;
	wire pin2 = pincfg_q[BIT_P2_POL] ? lvl2 : ~lvl2;
	logic [31:0] start_q;             // power-up pin release count
	wire  started = (start_q == 32'h0000_0000);

	// pins stay undriven during the power-up interval
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_q <= 32'(STARTUP_CYCLES);
		end else if (!started) begin
			start_q <= start_q - 32'h0000_0001;
		end
	end

	// push-pull drives both levels, open-drain only pulls low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_pin_first     <= 1'b0;
			irq_pin_first_oe  <= 1'b0;
			irq_pin_second    <= 1'b0;
			irq_pin_second_oe <= 1'b0;
		end else begin
			irq_pin_first  <= pincfg_q[BIT_P1_DRV] & pin1;
			irq_pin_second <= pincfg_q[BIT_P2_DRV] & pin2;
			irq_pin_first_oe  <= started
				& (pincfg_q[BIT_P1_DRV] | ~pin1);
			irq_pin_second_oe <= started
				& (pincfg_q[BIT_P2_DRV] | ~pin2);
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata    = prdata_q;
	assign pready    = pready_q;
	assign pslverr   = pslverr_q;
	assign src_data  = src_q[BIT_SRC_DATA];
	assign src_tap   = src_q[BIT_SRC_TAP];
	assign src_slope = src_q[BIT_SRC_SLP];
	assign src_low   = src_q[BIT_SRC_LOW];

endmodule : msic_top

/* File: sim/msic_checker.sv */
// concurrent checks on the first pin, source selects and startup of the controller
`timescale 1ns/100ps
module msic_checker
	import msic_pkg::*;
#(
	parameter int STARTUP_CYCLES = STARTUP_CYC  // pin release delay
) (
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [7:0]         paddr,
	input wire logic [31:0]        pwdata,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire logic [NUM_ENG-1:0] eng_cond,
	input wire logic               acc_update,
	input wire logic               src_data,
	input wire logic               src_tap,
	input wire logic               src_slope,
	input wire logic               src_low,
	input wire logic               irq_pin_first,
	input wire logic               irq_pin_first_oe
);
	// ------------------------------------------------------------
	// shadow of the configuration as written over the bus
	// ------------------------------------------------------------
	logic [7:0]         sh_q [64];  // written register bytes
	logic [2:0]         recent_q;   // counts down after any accepted write
	int                 cnt_q;      // cycles since reset release
	logic               wr_ok, started, pol1, drv1, nd_off, act1, hot;
	logic               latched;
	logic [3:0]         mode;
	logic [NUM_ENG-1:0] en, map1;
	assign wr_ok   = psel && penable && pready && pwrite && !pslverr;
	assign started = (cnt_q == STARTUP_CYCLES + 2);
	assign pol1    = sh_q[IDX_PINCFG][BIT_P1_POL];
	assign drv1    = sh_q[IDX_PINCFG][BIT_P1_DRV];
	assign nd_off  = !sh_q[IDX_EN_ND][BIT_ND_EN];
	assign mode    = sh_q[IDX_MODE][3:0];
	assign latched = (mode[2:0] == 3'h7);
	assign en      = sh_q[IDX_EN_ENG][NUM_ENG-1:0];
	assign map1    = sh_q[IDX_MAP1][NUM_ENG-1:0];
	assign hot     = |(eng_cond & en & map1);
	// pin seen as asserted, for either driver type
	assign act1 = drv1 ? (irq_pin_first == pol1) : (!irq_pin_first_oe == pol1);
	// shadow update on every accepted write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int j = 0; j < 64; j++) sh_q[j] <= 8'h00;
			sh_q[IDX_PINCFG] <= {4'h0, RST_PINCFG};
		end else if (wr_ok) begin
			sh_q[paddr[7:2]] <= pwdata[7:0];
		end
	end
	// write recency and startup counters
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			recent_q <= 3'h0;
			cnt_q    <= 0;
		end else begin
			recent_q <= wr_ok ? 3'h6 : recent_q - (recent_q != 3'h0);
			cnt_q    <= cnt_q + (cnt_q < STARTUP_CYCLES + 2);
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_startup_quiet: assert property (
		$rose(presetn) |-> !irq_pin_first_oe [*8]
	) else $error("first pin driven during startup");
	a_source_follow: assert property (
		wr_ok && paddr[7:2] == IDX_SRC |=>
		{src_low, src_slope, src_tap, src_data} == $past(pwdata[3:0])
	) else $error("source selects differ from written value");
	a_open_drain: assert property (
		!drv1 && $stable(drv1) |-> !irq_pin_first
	) else $error("open drain pin drives high");
	a_push_pull: assert property (
		started && drv1 && $stable(drv1) |-> irq_pin_first_oe
	) else $error("push pull pin not driven");
	a_event_pin: assert property (
		started && recent_q == 3'h0 && acc_update && hot |-> ##2 act1
	) else $error("pin not asserted two cycles after event");
	a_disable_clear: assert property (
		started && wr_ok && paddr[7:2] == IDX_EN_ENG && pwdata[6:0] == 7'h00
		&& nd_off |-> ##[1:3] !act1
	) else $error("pin still asserted after disable");
	a_latch_hold: assert property (
		started && latched && nd_off && $fell(act1) |-> recent_q != 3'h0
	) else $error("latched pin fell without a write");
	a_cond_hold: assert property (
		(started && recent_q == 3'h0 && nd_off && act1 && hot) [*3] |=> act1
	) else $error("pin cleared while condition holds");
	a_temp_clear: assert property (
		started && mode == 4'h9 && nd_off && $rose(act1) && eng_cond == 7'h00
		|-> ##[1:12] !act1
	) else $error("short hold did not expire");
	c_rise: cover property (acc_update && hot ##2 act1);
	c_latch: cover property (latched && $fell(act1));
	c_temp: cover property (mode == 4'h9 && $fell(act1));
endmodule : msic_checker

bind msic_top msic_checker #(.STARTUP_CYCLES(STARTUP_CYCLES)) chk (.*);

/* File: sim/msic_host_model.sv */
// host model: resolves the interrupt lines and masks the startup window
`timescale 1ns/100ps
module msic_host_model #(
	parameter int IGNORE_CYCLES = 10  // startup span the host ignores
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic pin_first,
	input  wire logic oe_first,
	input  wire logic pin_second,
	input  wire logic oe_second,
	output logic      line_first,
	output logic      line_second,
	output logic      pins_valid
);
	int wait_q;  // cycles since reset release
	// board pull-up wins wherever a pin is released
	assign line_first  = oe_first ? pin_first : 1'b1;
	assign line_second = oe_second ? pin_second : 1'b1;
	// pins are trusted only after the startup window
	assign pins_valid = (wait_q >= IGNORE_CYCLES);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_q <= 0;
		end else if (wait_q < IGNORE_CYCLES) begin
			wait_q <= wait_q + 1;
		end
	end
endmodule : msic_host_model

/* File: sim/test_msic_top.sv */
// self-checking bench of the interrupt controller
`timescale 1ns/100ps
module test_msic_top
	import msic_pkg::*;
;
	localparam int TK = 4;   // cycles per hold tick
	localparam int QT = 5;   // new-data quiet cycles
	localparam int SU = 10;  // startup cycles
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, acc_update = 1'b0, z_stored = 1'b0;
	logic        acq_start = 1'b0, pready, pslverr, er;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, v;
	logic [6:0]  eng_cond = 7'h00, m;
	logic        src_data, src_tap, src_slope, src_low, pins_valid;
	logic        p1, p1_oe, p2, p2_oe, line_first, line_second;
	logic [3:0]  cfg = 4'hF;
	logic [31:0] rs = 32'h00015DD4;  // random state
	int          bad_count = 0, total_checks = 0, k, i;
	logic [3:0]  codes [8] = '{4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'h1, 4'h2};
	int          ticks [8] = '{2, 2, 4, 50, 100, 200, 1000, 2000};
	always #2 pclk = ~pclk;
	msic_top #(.TICK_CYCLES(TK), .QUIET_CYCLES(QT), .STARTUP_CYCLES(SU)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .eng_cond(eng_cond),
		.acc_update(acc_update), .z_stored(z_stored), .acq_start(acq_start),
		.src_data(src_data), .src_tap(src_tap), .src_slope(src_slope),
		.src_low(src_low), .irq_pin_first(p1), .irq_pin_first_oe(p1_oe),
		.irq_pin_second(p2), .irq_pin_second_oe(p2_oe));
	msic_host_model #(.IGNORE_CYCLES(SU)) host (.pclk(pclk),
		.presetn(presetn), .pin_first(p1), .oe_first(p1_oe),
		.pin_second(p2), .oe_second(p2_oe), .line_first(line_first),
		.line_second(line_second), .pins_valid(pins_valid));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction : rnd
	// expected line level and drive enable of a pin
	function automatic logic lvl(input logic act, input logic pol);
		return act ? pol : !pol;
	endfunction : lvl
	function automatic logic oe_of(input logic act, pol, drv);
		return drv | !lvl(act, pol);
	endfunction : oe_of
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic end_of_test();
		if (bad_count == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test
	// one apb transfer; pready is sampled at the rising edge, where the
	// request still stands, and the answer is taken at that same edge
	task automatic apb(input logic w, input logic [5:0] ix,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= {ix, 2'b00};
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) bad_count++;
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdc(input string what, input logic [5:0] ix,
		input logic [31:0] exp);
		apb(1'b0, ix, 32'h0);
		check(what, rd, exp);
	endtask : rdc
	// acceleration update with the given conditions
	task automatic ev(input logic [6:0] c);
		@(posedge pclk);
		eng_cond   <= c;
		acc_update <= 1'b1;
		@(posedge pclk);
		acc_update <= 1'b0;
	endtask : ev
	task automatic pulse(input logic [1:0] s);
		@(posedge pclk);
		z_stored  <= s[0];
		acq_start <= s[1];
		@(posedge pclk);
		z_stored  <= 1'b0;
		acq_start <= 1'b0;
	endtask : pulse
	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask : settle
	task automatic pins(input logic a1, input logic a2);
		check("line1", 32'(line_first), 32'(lvl(a1, cfg[0])));
		check("oe1", 32'(p1_oe), 32'(oe_of(a1, cfg[0], cfg[1])));
		check("line2", 32'(line_second), 32'(lvl(a2, cfg[2])));
		check("oe2", 32'(p2_oe), 32'(oe_of(a2, cfg[2], cfg[3])));
	endtask : pins
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		check("oe start", 32'({p1_oe, p2_oe}), 32'h0);
		rdc("pin config", IDX_PINCFG, 32'h0F);
		rdc("mode", IDX_MODE, 32'h0);
		rdc("reserved", IDX_MAP_RS, 32'h0);
		apb(1'b1, 6'h3F, 32'hFFFFFFFF);
		check("unmapped", 32'(er), 32'h1);
		apb(1'b1, IDX_STATUS, 32'h7F);
		rdc("status ro", IDX_STATUS, 32'h0);
		check("valid", 32'(pins_valid), 32'h1);
		for (k = 0; k < 4; k++) begin
			v = rnd() & 32'hF;
			apb(1'b1, IDX_SRC, v);
			@(negedge pclk);
			check("src", 32'({src_low, src_slope, src_tap, src_data}), v);
		end
		apb(1'b1, IDX_SRC, 32'hFF);
		rdc("src rb", IDX_SRC, 32'h0F);
		// mapping, level and driver over random engines
		for (k = 0; k < 4; k++) begin
			cfg = 4'(rnd());
			cfg[1:0] = 2'(k);
			i = int'(rnd() % 32'h5);
			m = 7'(1 << i);
			apb(1'b1, IDX_PINCFG, 32'(cfg));
			apb(1'b1, IDX_MAP1, 32'(m));
			apb(1'b1, IDX_MAP2, k[0] ? 32'(m) : 32'h0);
			apb(1'b1, IDX_EN_ENG, 32'(m));
			eng_cond <= m;
			rdc("no update", IDX_STATUS, 32'h0);
			ev(m);
			settle(1);
			pins(1'b1, k[0]);
			rdc("status", IDX_STATUS, 32'(m));
			ev(7'h00);
			settle(1);
			pins(1'b0, 1'b0);
			ev(m);
			apb(1'b1, IDX_EN_ENG, 32'h0);
			settle(3);
			pins(1'b0, 1'b0);
			rdc("disabled", IDX_STATUS, 32'h0);
			eng_cond <= 7'h00;
		end
		// latched mode
		cfg = 4'hF;
		apb(1'b1, IDX_PINCFG, 32'h0F);
		apb(1'b1, IDX_MAP1, 32'h01);
		apb(1'b1, IDX_MAP2, 32'h0);
		apb(1'b1, IDX_EN_ENG, 32'h01);
		apb(1'b1, IDX_MODE, 32'h07);
		ev(7'h01);
		ev(7'h00);
		settle(2);
		pins(1'b1, 1'b0);
		apb(1'b1, IDX_MODE, 32'h8F);
		rdc("latch clear", IDX_STATUS, 32'h0);
		ev(7'h01);
		apb(1'b1, IDX_MODE, 32'h8F);
		rdc("clear held", IDX_STATUS, 32'h0);
		ev(7'h01);
		rdc("reassert", IDX_STATUS, 32'h01);
		eng_cond <= 7'h00;
		apb(1'b1, IDX_MODE, 32'h80);
		// temporary hold for codes 9 to E, 1 and 2
		for (k = 0; k < 8; k++) begin
			apb(1'b1, IDX_MODE, 32'(codes[k]));
			ev(7'h01);
			eng_cond <= 7'h00;
			settle(1);
			pins(1'b1, 1'b0);
			settle((ticks[k] - 1) * TK - 3);
			pins(1'b1, 1'b0);
			settle(10);
			pins(1'b0, 1'b0);
		end
		apb(1'b1, IDX_MODE, 32'h09);
		ev(7'h01);
		settle(20);
		pins(1'b1, 1'b0);
		@(posedge pclk);
		eng_cond <= 7'h00;
		settle(12);
		pins(1'b0, 1'b0);
		// orientation keeps its own fixed hold, second non-latched code
		apb(1'b1, IDX_MODE, 32'h08);
		apb(1'b1, IDX_MAP1, 32'h20);
		apb(1'b1, IDX_EN_ENG, 32'h20);
		ev(7'h20);
		ev(7'h00);
		settle(3);
		pins(1'b1, 1'b0);
		settle(50 * TK + 8);
		pins(1'b0, 1'b0);
		apb(1'b1, IDX_EN_ENG, 32'h0);
		// new data ignores the latched mode
		apb(1'b1, IDX_MODE, 32'h07);
		apb(1'b1, IDX_MAP1, 32'h80);
		apb(1'b1, IDX_EN_ND, 32'h01);
		pulse(2'b01);
		settle(1);
		pins(1'b1, 1'b0);
		rdc("nd set", IDX_NDSTAT, 32'h80);
		pulse(2'b10);
		rdc("nd clear", IDX_NDSTAT, 32'h0);
		pulse(2'b10);
		pulse(2'b01);
		rdc("nd quiet", IDX_NDSTAT, 32'h0);
		settle(QT + 2);
		pulse(2'b01);
		rdc("nd again", IDX_NDSTAT, 32'h80);
		apb(1'b1, IDX_EN_ND, 32'h0);
		rdc("nd off", IDX_NDSTAT, 32'h0);
		end_of_test();
	end
	// watchdog against a hang
	initial begin
		repeat (30000) @(posedge pclk);
		bad_count++;
		end_of_test();
	end
endmodule : test_msic_top
